/* File: verilog/flar_checker.sv */
module flar_checker (
   input wire logic sys_clk_i,
   input wire logic rstn_i,
   input wire flar_pkg::flar_axi_req_s axi_i,
   output flar_pkg::flar_axi_rsp_s axi_o,
   input wire flar_pkg::flar_req_s req_i,
   output flar_pkg::flar_rsp_s rsp_o,
   output flar_pkg::flar_snoop_s snoop_o
);
   flar_pkg::flar_state_s st_ff;
   flar_pkg::flar_state_s nxt_st;

   // ************************************************************
   // per-level walk attributes
   // ************************************************************
   logic [flar_pkg::LEVELS-1:0] used_l;
   logic [flar_pkg::LEVELS-1:0] us_l;
   logic [flar_pkg::LEVELS-1:0] rw_l;
   logic [flar_pkg::LEVELS-1:0] exb_l;
   logic [flar_pkg::LEVELS-1:0] fin_l;
   logic [flar_pkg::LEVELS-1:0] upd_we_c;
   logic [flar_pkg::LEVELS-1:0][63:0] upd_c;
   logic is_wr;
   logic ok_c;

   assign is_wr = (req_i.kind != flar_pkg::FLAR_RD);

   for (genvar i = 0; i < flar_pkg::LEVELS; i++) begin : g_lvl
      assign used_l[i] = (3'(i) < req_i.levels_used);
      assign fin_l[i] = (3'(i + 1) == req_i.levels_used);
      assign us_l[i] = req_i.entry[i][flar_pkg::US_BIT];
      assign rw_l[i] = req_i.entry[i][flar_pkg::RW_BIT];
      assign exb_l[i] = req_i.entry[i][flar_pkg::EXB_BIT];
      // only bits are or-ed in, so set flags stay set
      always_comb begin
         upd_c[i] = req_i.entry[i];
         upd_c[i][flar_pkg::A_BIT] = 1'b1;
         if (st_ff.ctrl[flar_pkg::CTRL_EAT]) begin
            upd_c[i][flar_pkg::EXT_ACC_BIT] = 1'b1;
         end
         if (is_wr && fin_l[i]) begin
            upd_c[i][flar_pkg::D_BIT] = 1'b1;
         end
      end
      // skip the atomic update when every flag is already set
      assign upd_we_c[i] = used_l[i] && ok_c && (upd_c[i] != req_i.entry[i]);
   end

   logic all_user;
   logic any_kernel;
   logic all_wr;
   logic no_exb;
   logic lvl_bad;
   logic no_xlate_c;
   logic rights_c;
   logic sup;
   logic no_exec;
   logic kxg;

   // rights are judged on the entries as handed over, possibly cached copies
   assign all_user = &(us_l | ~used_l);
   assign any_kernel = |(~us_l & used_l);
   assign all_wr = &(rw_l | ~used_l);
   assign no_exb = ~|(exb_l & used_l);
   assign lvl_bad = (req_i.levels_used < flar_pkg::LVL_MIN) ||
                    (req_i.levels_used > flar_pkg::LVL_MAX);
   assign sup = req_i.supervisor_request_flag;
   assign no_exec = st_ff.ctrl[flar_pkg::CTRL_NOEX];
   assign kxg = st_ff.ctrl[flar_pkg::CTRL_KXG];

   // unsupported capabilities and out-of-range level counts fall back to no translation
   assign no_xlate_c = !req_i.xlate_ok || lvl_bad ||
      (sup && !req_i.supervisor_allow_bit) ||
      (req_i.execute_request_flag && !flar_pkg::CAP_VALUE[flar_pkg::CAP_EXEC]) ||
      (sup && !flar_pkg::CAP_VALUE[flar_pkg::CAP_PRIV]);

   always_comb begin
      rights_c = 1'b1;
      if (sup) begin
         if (is_wr) begin
            rights_c = !st_ff.ctrl[flar_pkg::CTRL_WGE] || all_wr;
         end else if (req_i.execute_request_flag) begin
            rights_c = (!kxg || any_kernel) && (!no_exec || no_exb);
         end else begin
            rights_c = 1'b1;
         end
      end else begin
         if (is_wr) begin
            rights_c = all_wr && all_user;
         end else if (req_i.execute_request_flag) begin
            rights_c = all_user && (!no_exec || no_exb);
         end else begin
            rights_c = all_user;
         end
      end
   end

   assign ok_c = !no_xlate_c && rights_c;

   // ************************************************************
   // state update
   // ************************************************************
   logic [31:0] rd_mux;
   logic rd_hit;

   always_comb begin
      rd_hit = 1'b1;
      rd_mux = 32'h0000_0000;
      case (axi_i.araddr)
         flar_pkg::CTRL_OFF: rd_mux = {28'h000_0000, st_ff.ctrl};
         flar_pkg::CAP_OFF: rd_mux = {29'h000_0000, flar_pkg::CAP_VALUE};
         flar_pkg::STAT_OFF: rd_mux = {st_ff.fault_cnt, st_ff.permit_cnt};
         default: rd_hit = 1'b0;
      endcase
   end

   always_comb begin
      nxt_st = st_ff;
      // one registered decision per request, flag updates only if permitted
      nxt_st.rsp.valid = req_i.valid;
      nxt_st.rsp.permit = req_i.valid && ok_c;
      nxt_st.rsp.fault = req_i.valid && !ok_c;
      nxt_st.rsp.no_xlate = req_i.valid && no_xlate_c;
      nxt_st.rsp.upd_we = req_i.valid ? upd_we_c : '0;
      if (req_i.valid) begin
         nxt_st.rsp.upd_entry = upd_c;
         if (ok_c) begin
            nxt_st.permit_cnt = st_ff.permit_cnt + 16'h0001;
         end else begin
            nxt_st.fault_cnt = st_ff.fault_cnt + 16'h0001;
         end
      end
      if (axi_i.awvalid && !st_ff.aw_full) begin
         nxt_st.aw_full = 1'b1;
         nxt_st.awaddr = axi_i.awaddr;
      end
      if (axi_i.wvalid && !st_ff.w_full) begin
         nxt_st.w_full = 1'b1;
         nxt_st.wdata = axi_i.wdata;
         nxt_st.wstrb = axi_i.wstrb;
      end
      if (st_ff.bvalid && axi_i.bready) begin
         nxt_st.bvalid = 1'b0;
      end
      if (st_ff.aw_full && st_ff.w_full && !st_ff.bvalid) begin
         nxt_st.aw_full = 1'b0;
         nxt_st.w_full = 1'b0;
         nxt_st.bvalid = 1'b1;
         nxt_st.bresp = flar_pkg::RESP_OKAY;
         case (st_ff.awaddr)
            flar_pkg::CTRL_OFF: begin
               if (st_ff.wstrb[0]) begin
                  nxt_st.ctrl = st_ff.wdata[3:0];
               end
            end
            flar_pkg::CAP_OFF, flar_pkg::STAT_OFF: nxt_st.bresp = flar_pkg::RESP_OKAY;
            default: nxt_st.bresp = flar_pkg::RESP_SLVERR;
         endcase
      end
      if (st_ff.rvalid && axi_i.rready) begin
         nxt_st.rvalid = 1'b0;
      end
      if (axi_i.arvalid && !st_ff.rvalid) begin
         nxt_st.rvalid = 1'b1;
         nxt_st.rdata = rd_mux;
         nxt_st.rresp = rd_hit ? flar_pkg::RESP_OKAY : flar_pkg::RESP_SLVERR;
      end
   end

   always_ff @(posedge sys_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         st_ff <= flar_pkg::ST_RESET;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ************************************************************
   // outputs
   // ************************************************************
   assign axi_o.awready = !st_ff.aw_full;
   assign axi_o.wready = !st_ff.w_full;
   assign axi_o.bvalid = st_ff.bvalid;
   assign axi_o.bresp = st_ff.bresp;
   assign axi_o.arready = !st_ff.rvalid;
   assign axi_o.rvalid = st_ff.rvalid;
   assign axi_o.rdata = st_ff.rdata;
   assign axi_o.rresp = st_ff.rresp;
   assign rsp_o = st_ff.rsp;

   // no-snoop hint is deliberately ignored for the page itself
   assign snoop_o.root_ctx = flar_pkg::CAP_VALUE[flar_pkg::CAP_COH];
   assign snoop_o.pasid = 1'b1;
   assign snoop_o.paging = 1'b1;
   assign snoop_o.page = 1'b1;

   // ************************************************************
   // checks
   // ************************************************************
   default clocking cb @(posedge sys_clk_i); endclocking
   default disable iff (!rstn_i);

   logic good_c;
   assign good_c = req_i.valid && !no_xlate_c;

   property p_sup_read;
      good_c && sup && !is_wr && !req_i.execute_request_flag |=> rsp_o.permit;
   endproperty
   a_sup_read: assert property (p_sup_read) else $error("supervisor read refused");

   property p_kxg_fetch;
      good_c && sup && !is_wr && req_i.execute_request_flag && kxg && !any_kernel
         |=> rsp_o.fault && !rsp_o.permit && (rsp_o.upd_we == '0);
   endproperty
   a_kxg_fetch: assert property (p_kxg_fetch) else $error("user-only fetch allowed");

   property p_noexec_fetch;
      good_c && sup && !is_wr && req_i.execute_request_flag && no_exec && !no_exb
         |=> rsp_o.fault;
   endproperty
   a_noexec_fetch: assert property (p_noexec_fetch) else $error("blocked fetch allowed");

   property p_free_fetch;
      good_c && sup && !is_wr && req_i.execute_request_flag && !no_exec && !kxg
         |=> rsp_o.permit;
   endproperty
   a_free_fetch: assert property (p_free_fetch) else $error("free fetch refused");

   property p_wg_clear;
      good_c && sup && is_wr && !st_ff.ctrl[flar_pkg::CTRL_WGE] |=> rsp_o.permit;
   endproperty
   a_wg_clear: assert property (p_wg_clear) else $error("unguarded write refused");

   property p_user_read;
      req_i.valid && !sup && !is_wr && !all_user |=> rsp_o.fault && !rsp_o.permit;
   endproperty
   a_user_read: assert property (p_user_read) else $error("user read allowed");

   property p_user_write;
      good_c && !sup && is_wr && all_wr && all_user |=> rsp_o.permit;
   endproperty
   a_user_write: assert property (p_user_write) else $error("user write refused");

   property p_sticky;
      req_i.valid
         |=> (rsp_o.upd_entry[0] & $past(req_i.entry[0])) == $past(req_i.entry[0]);
   endproperty
   a_sticky: assert property (p_sticky) else $error("flag cleared");

   property p_accessed;
      req_i.valid && ok_c |=> rsp_o.upd_entry[0][flar_pkg::A_BIT];
   endproperty
   a_accessed: assert property (p_accessed) else $error("accessed not set");

   property p_no_sra;
      req_i.valid && sup && !req_i.supervisor_allow_bit
         |=> rsp_o.no_xlate && rsp_o.fault;
   endproperty
   a_no_sra: assert property (p_no_sra) else $error("supervisor passed without allow");

   property p_ctrl_write;
      st_ff.aw_full && st_ff.w_full && !st_ff.bvalid
         && st_ff.awaddr == flar_pkg::CTRL_OFF && st_ff.wstrb[0]
         |=> axi_o.bvalid && st_ff.ctrl == $past(st_ff.wdata[3:0]);
   endproperty
   a_ctrl_write: assert property (p_ctrl_write) else $error("control write lost");

   property p_both_fetch;
      good_c && sup && !is_wr && req_i.execute_request_flag && no_exec && kxg
         && !(any_kernel && no_exb) |=> rsp_o.fault && !rsp_o.permit;
   endproperty
   a_both_fetch: assert property (p_both_fetch) else $error("guarded fetch allowed");

   property p_both_fetch_ok;
      good_c && sup && !is_wr && req_i.execute_request_flag && no_exec && kxg
         && any_kernel && no_exb |=> rsp_o.permit;
   endproperty
   a_both_fetch_ok: assert property (p_both_fetch_ok) else $error("fetch refused");

   property p_wg_set;
      good_c && sup && is_wr && st_ff.ctrl[flar_pkg::CTRL_WGE] && !all_wr
         |=> rsp_o.fault && !rsp_o.permit;
   endproperty
   a_wg_set: assert property (p_wg_set) else $error("guarded write allowed");

   property p_wg_set_ok;
      good_c && sup && is_wr && st_ff.ctrl[flar_pkg::CTRL_WGE] && all_wr
         |=> rsp_o.permit;
   endproperty
   a_wg_set_ok: assert property (p_wg_set_ok) else $error("guarded write refused");

   property p_user_fetch;
      req_i.valid && !sup && !is_wr && req_i.execute_request_flag && no_exec && !no_exb
         |=> rsp_o.fault && !rsp_o.permit;
   endproperty
   a_user_fetch: assert property (p_user_fetch) else $error("user fetch allowed");

   property p_user_fetch_ok;
      good_c && !sup && !is_wr && req_i.execute_request_flag && all_user
         && (!no_exec || no_exb) |=> rsp_o.permit;
   endproperty
   a_user_fetch_ok: assert property (p_user_fetch_ok) else $error("user fetch refused");

   property p_user_wr_bad;
      req_i.valid && !sup && is_wr && !(all_wr && all_user)
         |=> rsp_o.fault && !rsp_o.permit;
   endproperty
   a_user_wr_bad: assert property (p_user_wr_bad) else $error("user write allowed");

   property p_ext_accessed;
      req_i.valid && ok_c && st_ff.ctrl[flar_pkg::CTRL_EAT]
         |=> rsp_o.upd_entry[0][flar_pkg::EXT_ACC_BIT] && rsp_o.upd_entry[0][flar_pkg::A_BIT];
   endproperty
   a_ext_accessed: assert property (p_ext_accessed) else $error("tracking not set");

   property p_dirty;
      req_i.valid && ok_c && is_wr && req_i.levels_used == flar_pkg::LVL_MAX
         |=> rsp_o.upd_entry[3][flar_pkg::D_BIT] && rsp_o.upd_entry[3][flar_pkg::A_BIT];
   endproperty
   a_dirty: assert property (p_dirty) else $error("dirty not set");

   property p_accessed_we;
      req_i.valid && ok_c && !req_i.entry[0][flar_pkg::A_BIT]
         |=> rsp_o.upd_we[0];
   endproperty
   a_accessed_we: assert property (p_accessed_we) else $error("accessed not written");

   property p_sticky_last;
      req_i.valid
         |=> (rsp_o.upd_entry[3] & $past(req_i.entry[3])) == $past(req_i.entry[3]);
   endproperty
   a_sticky_last: assert property (p_sticky_last) else $error("flag cleared");

   property p_decision;
      rsp_o.valid |-> rsp_o.permit != rsp_o.fault;
   endproperty
   a_decision: assert property (p_decision) else $error("decision not unique");

   property p_quiet;
      !rsp_o.valid |-> !rsp_o.permit && !rsp_o.fault && (rsp_o.upd_we == '0);
   endproperty
   a_quiet: assert property (p_quiet) else $error("result without request");

   property p_fault_no_upd;
      rsp_o.fault |-> (rsp_o.upd_we == '0) && !rsp_o.permit;
   endproperty
   a_fault_no_upd: assert property (p_fault_no_upd) else $error("faulted entry written");

   property p_lost_xlate;
      req_i.valid && !req_i.xlate_ok
         |=> rsp_o.no_xlate && rsp_o.fault;
   endproperty
   a_lost_xlate: assert property (p_lost_xlate) else $error("missing walk passed");

   property p_cap_read;
      axi_i.arvalid && axi_o.arready && axi_i.araddr == flar_pkg::CAP_OFF
         |=> axi_o.rvalid && axi_o.rdata[2:0] == flar_pkg::CAP_VALUE;
   endproperty
   a_cap_read: assert property (p_cap_read) else $error("capability read wrong");
endmodule

/* File: shared/flar_pkg.sv */
package flar_pkg;
   // ************************************************************
   // geometry and entry bit positions
   // ************************************************************
   localparam int unsigned LEVELS = 4;
   localparam int unsigned A_BIT = 5;
   localparam int unsigned D_BIT = 6;
   localparam int unsigned EXT_ACC_BIT = 10;
   localparam int unsigned RW_BIT = 1;
   localparam int unsigned US_BIT = 2;
   localparam int unsigned EXB_BIT = 63;
   localparam logic [2:0] LVL_MIN = 3'h2;
   localparam logic [2:0] LVL_MAX = 3'h4;

   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [11:0] CTRL_OFF = 12'h000;
   localparam logic [11:0] CAP_OFF = 12'h004;
   localparam logic [11:0] STAT_OFF = 12'h008;
   localparam int unsigned CTRL_NOEX = 0;
   localparam int unsigned CTRL_KXG = 1;
   localparam int unsigned CTRL_WGE = 2;
   localparam int unsigned CTRL_EAT = 3;
   localparam logic [3:0] CTRL_RESET = 4'h0;
   localparam int unsigned CAP_EXEC = 0;
   localparam int unsigned CAP_PRIV = 1;
   localparam int unsigned CAP_COH = 2;
   localparam logic [2:0] CAP_VALUE = 3'h7;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // ************************************************************
   // carriers
   // ************************************************************
   typedef enum logic [1:0] {FLAR_RD, FLAR_WR, FLAR_AT} flar_kind_e;

   typedef struct packed {
      logic valid;
      logic supervisor_request_flag;
      logic execute_request_flag;
      flar_kind_e kind;
      logic supervisor_allow_bit;
      logic nosnoop_hint;
      logic xlate_ok;
      logic [2:0] levels_used;
      logic [LEVELS-1:0][63:0] entry;
   } flar_req_s;

   typedef struct packed {
      logic valid;
      logic permit;
      logic fault;
      logic no_xlate;
      logic [LEVELS-1:0] upd_we;
      logic [LEVELS-1:0][63:0] upd_entry;
   } flar_rsp_s;

   typedef struct packed {
      logic root_ctx;
      logic pasid;
      logic paging;
      logic page;
   } flar_snoop_s;

   typedef struct packed {
      logic awvalid;
      logic [11:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [11:0] araddr;
      logic rready;
   } flar_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } flar_axi_rsp_s;

   typedef struct packed {
      logic [3:0] ctrl;
      logic aw_full;
      logic [11:0] awaddr;
      logic w_full;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic [15:0] permit_cnt;
      logic [15:0] fault_cnt;
      flar_rsp_s rsp;
   } flar_state_s;

   localparam flar_state_s ST_RESET = '{ctrl: CTRL_RESET, default: '0};
endpackage

/* File: test/flar_endpoint.sv */
// ************************************************************
// endpoint issuing checked requests
// ************************************************************
module flar_endpoint (
   input wire logic sys_clk_i,
   input wire flar_pkg::flar_rsp_s rsp_i,
   output flar_pkg::flar_req_s req_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial req_o = '0;

   // gap gives a slow endpoint; idle fields are inverted, not held
   task automatic send(input flar_pkg::flar_req_s r, input int gap,
                       output flar_pkg::flar_rsp_s rs);
      flar_pkg::flar_req_s idle;
      idle = ~r;
      idle.valid = 1'b0;
      repeat (gap) @(posedge sys_clk_i);
      @(posedge sys_clk_i);
      req_o <= r;
      @(posedge sys_clk_i);
      req_o <= idle;
      #1 rs = rsp_i;
   endtask
endmodule

/* File: test/first_level_access_rights_tb.sv */
module first_level_access_rights_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk_i = 1'b0;
   logic rstn_i = 1'b0;
   flar_pkg::flar_axi_req_s axi = '0;
   flar_pkg::flar_axi_rsp_s axi_o;
   flar_pkg::flar_req_s req;
   flar_pkg::flar_rsp_s rsp;
   flar_pkg::flar_snoop_s snoop;
   int n_mismatch = 0;
   int check_count = 0;
   logic [15:0] n_ok = 16'h0000;
   logic [15:0] n_bad = 16'h0000;

   always #10 sys_clk_i = ~sys_clk_i;

   flar_checker dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i), .axi_i(axi), .axi_o(axi_o),
                     .req_i(req), .rsp_o(rsp), .snoop_o(snoop));
   flar_endpoint ep (.sys_clk_i(sys_clk_i), .rsp_i(rsp), .req_o(req));

   task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
      check_count++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
      end
   endtask

   task automatic report_and_stop;
      if (n_mismatch == 0 && check_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   // ************************************************************
   // register bus master
   // ************************************************************
   task automatic axi_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      @(posedge sys_clk_i);
      axi.awaddr <= a;
      axi.wdata <= d;
      axi.wstrb <= 4'hF;
      axi.awvalid <= 1'b1;
      axi.wvalid <= 1'b1;
      axi.bready <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         if (aw && axi_o.awready === 1'b1) begin
            aw = 1'b0;
            axi.awvalid <= 1'b0;
         end
         if (w && axi_o.wready === 1'b1) begin
            w = 1'b0;
            axi.wvalid <= 1'b0;
         end
      end while (axi_o.bvalid !== 1'b1);
      axi.bready <= 1'b0;
      chk(axi_o.bresp, er, "write response");
   endtask

   task automatic axi_rd(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
      logic ar;
      ar = 1'b1;
      @(posedge sys_clk_i);
      axi.araddr <= a;
      axi.arvalid <= 1'b1;
      axi.rready <= 1'b1;
      do begin
         @(posedge sys_clk_i);
         if (ar && axi_o.arready === 1'b1) begin
            ar = 1'b0;
            axi.arvalid <= 1'b0;
         end
      end while (axi_o.rvalid !== 1'b1);
      axi.rready <= 1'b0;
      chk(axi_o.rdata, d, "read data");
      chk(axi_o.rresp, er, "read response");
   endtask

   // ************************************************************
   // tests
   // ************************************************************
   initial begin
      flar_pkg::flar_req_s r;
      flar_pkg::flar_rsp_s q;
      logic ok;
      logic nx;
      logic sup;
      logic we;
      logic [63:0] ue;
      int s;
      int x;
      int k;
      int p;
      int lv;
      repeat (16) @(posedge sys_clk_i);
      rstn_i <= 1'b1;
      axi_rd(flar_pkg::CTRL_OFF, 32'h00000000, flar_pkg::RESP_OKAY);
      axi_rd(flar_pkg::CAP_OFF, 32'h00000007, flar_pkg::RESP_OKAY);
      axi_wr(flar_pkg::CAP_OFF, 32'h00000000, flar_pkg::RESP_OKAY);
      axi_rd(flar_pkg::CAP_OFF, 32'h00000007, flar_pkg::RESP_OKAY);
      axi_wr(12'h00C, 32'hFFFFFFFF, flar_pkg::RESP_SLVERR);
      axi_rd(12'h00C, 32'h00000000, flar_pkg::RESP_SLVERR);
      for (int c = 0; c < 16; c++) begin
         axi_wr(flar_pkg::CTRL_OFF, 32'(c), flar_pkg::RESP_OKAY);
         axi_rd(flar_pkg::CTRL_OFF, 32'(c), flar_pkg::RESP_OKAY);
         // s: user, supervisor allowed, supervisor refused
         for (int m = 0; m < 144; m++) begin
            s = m / 48;
            x = (m / 24) % 2;
            k = (m / 8) % 3;
            p = m % 8;
            sup = (s != 0);
            lv = 2 + (p + c) % 3;
            r = '0;
            r.valid = 1'b1;
            r.supervisor_request_flag = sup;
            r.supervisor_allow_bit = (s == 1);
            r.execute_request_flag = x[0];
            r.kind = flar_pkg::flar_kind_e'(k);
            r.nosnoop_hint = p[0];
            r.xlate_ok = 1'b1;
            r.levels_used = 3'(lv);
            // level 0 carries a dirty flag, level 1 accessed flags already set
            for (int i = 0; i < 4; i++)
               r.entry[i] = 64'h7 | (i == 0 ? 64'h40 : 64'h0) | (i == 1 ? 64'h420 : 64'h0);
            r.entry[lv-1][flar_pkg::US_BIT] = !p[0];
            r.entry[0][flar_pkg::RW_BIT] = !p[1];
            r.entry[0][flar_pkg::EXB_BIT] = p[2];
            if (k != 0)
               ok = sup ? (!c[2] || !p[1]) : (!p[1] && !p[0]);
            else if (x != 0)
               ok = (sup ? (!c[1] || p[0]) : !p[0]) && (!c[0] || !p[2]);
            else
               ok = sup || !p[0];
            nx = (s == 2);
            if (x == 1 && k == 2 && p >= 5) begin
               nx = 1'b1;
               if (p == 7)
                  r.xlate_ok = 1'b0;
               else
                  r.levels_used = (p == 5) ? 3'h5 : 3'h1;
            end
            ok = ok && !nx;
            n_ok += 16'(ok);
            n_bad += 16'(!ok);
            ep.send(r, p % 2, q);
            chk(q.valid, 1'b1, "response valid");
            chk(q.no_xlate, nx, "no translation");
            chk(q.permit, ok, "permit");
            chk(q.fault, !ok, "fault");
            chk(snoop, 4'hF, "snoop");
            for (int i = 0; i < 4; i++) begin
               ue = r.entry[i] | 64'h20 | (c[3] ? 64'h400 : 64'h0);
               ue = ue | ((k != 0 && i == lv - 1) ? 64'h40 : 64'h0);
               we = ok && i < lv && ue != r.entry[i];
               chk(q.upd_we[i], we, "flag write");
               if (we)
                  chk(q.upd_entry[i], ue, "flag value");
            end
         end
      end
      axi_rd(flar_pkg::STAT_OFF, {n_bad, n_ok}, flar_pkg::RESP_OKAY);
      report_and_stop();
   end

   // expected run is about six thousand cycles
   initial begin
      repeat (40000) @(posedge sys_clk_i);
      n_mismatch++;
      report_and_stop();
   end
endmodule
